// file: logic/tqa_arbiter.sv
// Transfer request queue arbiter: admission credits, priority queues, command issue
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Three queues: urgent 6 entries, high 13 entries, low 11 entries.
// - Credit caps: memory 6 urgent, quick 3 high 3 low, channel 8/8, host 2 high.
// - A credit is held from queueing until the request enters its register set.
// - A request arriving with its credits exhausted stalls its requestor instead.
// - A stall clears only when that requestor's request on that level is taken.
// - A stalled memory controller gets nothing accepted on any level.
// - Unstalled requestors are forwarded in order; stalled ones forward nothing.
// - Simultaneous requests are granted round robin, one per cycle.
// - Each queue is first-in first-out, delivering one request at a time.
// - Each level's register set takes its queue head whenever it is idle.
// - Up to three transfers run at once, one per register set.
// - Active transfers issue port commands; the higher priority wins a port.
// - A port counts as busy only through occupied command buffers.
// - Bursts issue while a port has a free buffer and pause when full.
// - Second-level memory port has 8 read buffers of 2 words.
// - External memory port has 2 write buffers of 16 words.
// - Urgent ranks above high, high above low.
// - A port may leave a low transfer for a higher one, then resume it.
// - Ports execute buffered commands in arrival order.
// - A newly loaded higher-priority set wins command issue at once.
// - Read and write command pipelines issue independently in parallel.
module tqa_arbiter (
  // Clock and reset
  input  wire logic                                                clock,
  input  wire logic                                                rst_n,
  // Requestor side, valid held until ack
  input  wire logic [tqa_pkg::NUM_REQ-1:0]                         req_valid,
  input  wire logic [tqa_pkg::NUM_REQ-1:0][1:0]                    req_prio,
  input  wire logic [tqa_pkg::NUM_REQ-1:0][tqa_pkg::DATA_W-1:0]    req_data,
  output logic      [tqa_pkg::NUM_REQ-1:0]                         req_ack,
  output logic      [tqa_pkg::NUM_REQ-1:0]                         req_stall,
  // Read command pipeline
  output logic                                                     rd_cmd_valid,
  output logic      [tqa_pkg::PORT_W-1:0]                          rd_cmd_port,
  output logic      [1:0]                                          rd_cmd_prio,
  output logic      [tqa_pkg::WORDS_W-1:0]                         rd_cmd_words,
  // Write command pipeline
  output logic                                                     wr_cmd_valid,
  output logic      [tqa_pkg::PORT_W-1:0]                          wr_cmd_port,
  output logic      [1:0]                                          wr_cmd_prio,
  output logic      [tqa_pkg::WORDS_W-1:0]                         wr_cmd_words,
  // Port buffer completions, one pulse per command finished
  input  wire logic [tqa_pkg::NUM_PORT-1:0]                        port_rd_done,
  input  wire logic [tqa_pkg::NUM_PORT-1:0]                        port_wr_done,
  // Register set status
  output logic      [tqa_pkg::NUM_Q-1:0]                           set_active,
  output logic      [tqa_pkg::NUM_Q-1:0]                           xfer_done
);
  typedef struct packed {
    logic [tqa_pkg::NUM_REQ-1:0]                                  ack;
    logic [tqa_pkg::NUM_REQ-1:0]                                  stall;
    logic [tqa_pkg::NUM_REQ-1:0][1:0]                             stall_q;
    logic [1:0]                                                   rr;
    logic [tqa_pkg::NUM_REQ-1:0][tqa_pkg::NUM_Q-1:0][tqa_pkg::CNT_W-1:0] credit;
    logic [tqa_pkg::NUM_Q-1:0]                                    act;
    logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::PORT_W-1:0]               src;
    logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::PORT_W-1:0]               dst;
    logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::LEN_W-1:0]                rd_left;
    logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::LEN_W-1:0]                wr_left;
    logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::LEN_W-1:0]                ahead;
    logic [tqa_pkg::NUM_PORT-1:0][tqa_pkg::CNT_W-1:0]             rd_cnt;
    logic [tqa_pkg::NUM_PORT-1:0][tqa_pkg::CNT_W-1:0]             wr_cnt;
    logic                                                         rd_v;
    logic [tqa_pkg::PORT_W-1:0]                                   rd_port;
    logic [1:0]                                                   rd_prio;
    logic [tqa_pkg::WORDS_W-1:0]                                  rd_words;
    logic                                                         wr_v;
    logic [tqa_pkg::PORT_W-1:0]                                   wr_port;
    logic [1:0]                                                   wr_prio;
    logic [tqa_pkg::WORDS_W-1:0]                                  wr_words;
    logic [tqa_pkg::NUM_Q-1:0]                                    done;
  } tqa_state_type;

  localparam logic [tqa_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

  tqa_state_type                                     st;
  tqa_state_type                                     next_st;
  logic [tqa_pkg::NUM_Q-1:0]                         push;
  logic [tqa_pkg::ENTRY_W-1:0]                       push_data;
  logic [tqa_pkg::NUM_Q-1:0]                         pop;
  logic [tqa_pkg::NUM_Q-1:0][tqa_pkg::ENTRY_W-1:0]   head;
  logic [tqa_pkg::NUM_Q-1:0]                         empty;
  logic [tqa_pkg::NUM_REQ-1:0]                       release_stall;
  logic                                              over_limit;

  // One queue per level, each with its own depth
  genvar g;
  generate
    for (g = 0; g < tqa_pkg::NUM_Q; g++) begin : g_queue
      tqa_fifo #(
        .DEPTH(tqa_pkg::queue_depth(g))
      ) u_queue (
        .clock    (clock),
        .rst_n    (rst_n),
        .push     (push[g]),
        .push_data(push_data),
        .pop      (pop[g]),
        .head     (head[g]),
        .empty    (empty[g])
      );
    end
  endgenerate

  // Node arbitration, queue hand-off and both command pipelines
  always_comb begin
    int         r;
    logic [1:0] q;
    logic [1:0] hr;
    logic       found;
    logic       granted;
    logic [1:0] p;
    next_st       = st;
    push          = '0;
    push_data     = '0;
    pop           = '0;
    release_stall = '0;
    over_limit    = 1'b0;
    r             = 0;
    q             = '0;
    hr            = '0;
    found         = 1'b0;
    granted       = 1'b0;
    p             = '0;
    next_st.ack   = '0;
    next_st.done  = '0;
    next_st.rd_v  = 1'b0;
    next_st.wr_v  = 1'b0;

    // Idle register sets take their queue head; the credit returns here
    for (int k = 0; k < tqa_pkg::NUM_Q; k++) begin
      hr = head[k][tqa_pkg::DATA_W +: 2];
      if (!st.act[k] && !empty[k]) begin
        pop[k]            = 1'b1;
        next_st.act[k]    = 1'b1;
        next_st.src[k]    = head[k][tqa_pkg::F_SRC_LSB +: tqa_pkg::PORT_W];
        next_st.dst[k]    = head[k][tqa_pkg::F_DST_LSB +: tqa_pkg::PORT_W];
        next_st.rd_left[k] = head[k][tqa_pkg::F_LEN_LSB +: tqa_pkg::LEN_W];
        next_st.wr_left[k] = head[k][tqa_pkg::F_LEN_LSB +: tqa_pkg::LEN_W];
        next_st.ahead[k]  = '0;
        next_st.credit[hr][k] = st.credit[hr][k] - CNT_ONE;
        if (st.stall[hr] && st.stall_q[hr] == 2'(k)) begin
          release_stall[hr] = 1'b1;
          next_st.stall[hr] = 1'b0;
        end
      end
    end

    // Round robin over waiting requestors, one admitted per cycle
    for (int i = 0; i < tqa_pkg::NUM_REQ; i++) begin
      r = (int'(st.rr) + i) % tqa_pkg::NUM_REQ;
      q = req_prio[r];
      // Stalled requestors are skipped entirely, whatever level they ask for
      if (!found && req_valid[r] && !st.stall[r] && !st.ack[r]
          && q <= tqa_pkg::Q_LOW) begin
        found      = 1'b1;
        next_st.rr = 2'((r + 1) % tqa_pkg::NUM_REQ);
        if (st.credit[r][q] >= tqa_pkg::credit_limit(2'(r), q)) begin
          next_st.stall[r]   = 1'b1;
          next_st.stall_q[r] = q;
        end else begin
          push[q]   = 1'b1;
          push_data = {2'(r), req_data[r]};
          next_st.ack[r] = 1'b1;
          next_st.credit[r][q] = next_st.credit[r][q] + CNT_ONE;
        end
      end
    end

    // Buffers drain as ports finish commands; only full buffers block a port
    for (int k = 0; k < tqa_pkg::NUM_PORT; k++) begin
      if (port_rd_done[k] && st.rd_cnt[k] != '0)
        next_st.rd_cnt[k] = st.rd_cnt[k] - CNT_ONE;
      if (port_wr_done[k] && st.wr_cnt[k] != '0)
        next_st.wr_cnt[k] = st.wr_cnt[k] - CNT_ONE;
    end

    // Read pipeline: scan urgent first so a higher level always takes the port
    granted = 1'b0;
    for (int k = 0; k < tqa_pkg::NUM_Q; k++) begin
      p = st.src[k];
      if (!granted && st.act[k] && st.rd_left[k] != '0
          && st.rd_cnt[p] < tqa_pkg::buf_depth(p, 1'b0)) begin
        granted            = 1'b1;
        next_st.rd_v       = 1'b1;
        next_st.rd_port    = p;
        next_st.rd_prio    = 2'(k);
        next_st.rd_words   = tqa_pkg::buf_words(p, 1'b0);
        next_st.rd_cnt[p]  = next_st.rd_cnt[p] + CNT_ONE;
        next_st.rd_left[k] = st.rd_left[k] - 4'h1;
        next_st.ahead[k]   = st.ahead[k] + 4'h1;
      end
    end

    // Write pipeline runs beside the read one; a lower set resumes when freed
    granted = 1'b0;
    for (int k = 0; k < tqa_pkg::NUM_Q; k++) begin
      p = st.dst[k];
      if (!granted && st.act[k] && st.wr_left[k] != '0 && st.ahead[k] != '0
          && st.wr_cnt[p] < tqa_pkg::buf_depth(p, 1'b1)) begin
        granted            = 1'b1;
        next_st.wr_v       = 1'b1;
        next_st.wr_port    = p;
        next_st.wr_prio    = 2'(k);
        next_st.wr_words   = tqa_pkg::buf_words(p, 1'b1);
        next_st.wr_cnt[p]  = next_st.wr_cnt[p] + CNT_ONE;
        next_st.wr_left[k] = st.wr_left[k] - 4'h1;
        next_st.ahead[k]   = next_st.ahead[k] - 4'h1;
      end
    end

    // A set with nothing left retires and frees its level
    for (int k = 0; k < tqa_pkg::NUM_Q; k++) begin
      if (st.act[k] && st.rd_left[k] == '0 && st.wr_left[k] == '0) begin
        next_st.act[k]  = 1'b0;
        next_st.done[k] = 1'b1;
      end
    end

    // Helper for the credit check below
    for (int a = 0; a < tqa_pkg::NUM_REQ; a++)
      for (int b = 0; b < tqa_pkg::NUM_Q; b++)
        if (st.credit[a][b] > tqa_pkg::credit_limit(2'(a), 2'(b))) over_limit = 1'b1;
  end

  // All state in one register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state; ports keep arrival order on their own
  assign req_ack      = st.ack;
  assign req_stall    = st.stall;
  assign rd_cmd_valid = st.rd_v;
  assign rd_cmd_port  = st.rd_port;
  assign rd_cmd_prio  = st.rd_prio;
  assign rd_cmd_words = st.rd_words;
  assign wr_cmd_valid = st.wr_v;
  assign wr_cmd_port  = st.wr_port;
  assign wr_cmd_prio  = st.wr_prio;
  assign wr_cmd_words = st.wr_words;
  assign set_active   = st.act;
  assign xfer_done    = st.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // An idle urgent set facing a non-empty queue
  sequence urgent_take;
    !st.act[0] && !empty[0];
  endsequence

  // Urgent head leaving its queue with no new urgent entry behind it
  sequence urgent_pop;
    pop[0] && !push[0];
  endsequence

  credit_cap_a: assert property (!over_limit)
    else $error("credit counter above its limit");
  stall_hold_mc_a: assert property (st.stall[0] && !release_stall[0] |=> st.stall[0])
    else $error("memory requestor stall dropped without release");
  stall_hold_ch_a: assert property (st.stall[1] && !release_stall[1] |=> st.stall[1])
    else $error("channel requestor stall dropped without release");
  no_stall_ack_a: assert property ((st.ack & st.stall) == '0)
    else $error("stalled requestor acknowledged");
  ack_pulse_a: assert property (st.ack[0] |=> !st.ack[0])
    else $error("acknowledge held longer than one cycle");
  l2_rd_buf_a: assert property (st.rd_cnt[tqa_pkg::PORT_L2] <= tqa_pkg::L2_RD_BUFS)
    else $error("second level read buffers overfilled");
  ext_wr_buf_a: assert property (st.wr_cnt[tqa_pkg::PORT_EXT] <= tqa_pkg::EXT_WR_BUFS)
    else $error("external write buffers overfilled");
  set_load_a: assert property (urgent_take |=> st.act[0])
    else $error("urgent register set did not load its head");
  urgent_first_a: assert property (st.act[0] && st.rd_left[0] != '0 && st.rd_cnt[st.src[0]] == '0
      |=> st.rd_v && st.rd_prio == tqa_pkg::Q_URGENT)
    else $error("urgent transfer lost read issue to a lower level");
  retire_a: assert property (st.done != '0 |-> (st.done & st.act) == '0)
    else $error("retired set still active");
  stall_hold_hp_a: assert property (st.stall[2] && !release_stall[2] |=> st.stall[2])
    else $error("host requestor stall dropped without release");
  stall_block_a: assert property (st.stall[0] |=> !st.ack[0])
    else $error("stalled memory requestor acknowledged");
  credit_back_a: assert property (urgent_pop
      |=> st.credit[0][0] == $past(st.credit[0][0]) - CNT_ONE)
    else $error("urgent credit not returned on hand-off");

  // Full buffers hold back further commands to that port
  rd_full_pause_a: assert property (st.rd_cnt[tqa_pkg::PORT_L2] == tqa_pkg::L2_RD_BUFS
      |=> !(st.rd_v && st.rd_port == tqa_pkg::PORT_L2))
    else $error("read issued to a full second level port");
  wr_full_pause_a: assert property (st.wr_cnt[tqa_pkg::PORT_EXT] == tqa_pkg::EXT_WR_BUFS
      |=> !(st.wr_v && st.wr_port == tqa_pkg::PORT_EXT))
    else $error("write issued to a full external port");
endmodule
`default_nettype wire

// file: shared/tqa_pkg.sv
// Shared constants, field layout and decode functions for the transfer request arbiter
package tqa_pkg;
  // Requestor identities
  localparam int         NUM_REQ = 3;
  localparam logic [1:0] REQ_MC  = 2'h0;  // Memory controller: cache service and quick transfers
  localparam logic [1:0] REQ_CH  = 2'h1;  // Channel transfer engine
  localparam logic [1:0] REQ_HP  = 2'h2;  // Host port master

  // Priority levels, lower code wins
  localparam int         NUM_Q    = 3;
  localparam logic [1:0] Q_URGENT = 2'h0;
  localparam logic [1:0] Q_HIGH   = 2'h1;
  localparam logic [1:0] Q_LOW    = 2'h2;
  localparam int         QD_URGENT = 6;
  localparam int         QD_HIGH   = 13;
  localparam int         QD_LOW    = 11;
  localparam int         QD_MAX    = 13;
  localparam int         QIDX_W    = 4;

  // Per requestor and level credit limits
  localparam logic [3:0] LIM_MC_URGENT = 4'h6;
  localparam logic [3:0] LIM_MC_HIGH   = 4'h3;
  localparam logic [3:0] LIM_MC_LOW    = 4'h3;
  localparam logic [3:0] LIM_CH_HIGH   = 4'h8;
  localparam logic [3:0] LIM_CH_LOW    = 4'h8;
  localparam logic [3:0] LIM_HP_HIGH   = 4'h2;
  localparam logic [3:0] LIM_NONE      = 4'h0;
  localparam int         CNT_W         = 4;

  // Transfer request word: source port, destination port, burst count
  localparam int DATA_W    = 8;
  localparam int F_SRC_LSB = 6;
  localparam int F_DST_LSB = 4;
  localparam int F_LEN_LSB = 0;
  localparam int PORT_W    = 2;
  localparam int LEN_W     = 4;
  localparam int ENTRY_W   = DATA_W + 2;

  // Peripheral ports
  localparam int         NUM_PORT    = 4;
  localparam logic [1:0] PORT_L2     = 2'h0;  // second_level_memory
  localparam logic [1:0] PORT_EXT    = 2'h1;  // external_memory_port
  localparam logic [1:0] PORT_SERIAL = 2'h2;  // buffered_serial_peripheral
  localparam logic [1:0] PORT_AUX    = 2'h3;

  // Command buffers per port and direction
  localparam logic [3:0] L2_RD_BUFS   = 4'h8;
  localparam logic [4:0] L2_RD_WORDS  = 5'h02;
  localparam logic [3:0] EXT_WR_BUFS  = 4'h2;
  localparam logic [4:0] EXT_WR_WORDS = 5'h10;
  localparam logic [3:0] DEF_BUFS     = 4'h2;
  localparam logic [4:0] DEF_WORDS    = 5'h04;
  localparam int         WORDS_W      = 5;

  function automatic int queue_depth(input int q);
    queue_depth = (q == 0) ? QD_URGENT : (q == 1) ? QD_HIGH : QD_LOW;
  endfunction

  function automatic logic [3:0] credit_limit(input logic [1:0] r, input logic [1:0] q);
    logic [3:0] lim;
    lim = LIM_NONE;
    if (r == REQ_MC && q == Q_URGENT) lim = LIM_MC_URGENT;
    if (r == REQ_MC && q == Q_HIGH) lim = LIM_MC_HIGH;
    if (r == REQ_MC && q == Q_LOW) lim = LIM_MC_LOW;
    if (r == REQ_CH && q == Q_HIGH) lim = LIM_CH_HIGH;
    if (r == REQ_CH && q == Q_LOW) lim = LIM_CH_LOW;
    if (r == REQ_HP && q == Q_HIGH) lim = LIM_HP_HIGH;
    return lim;
  endfunction

  function automatic logic [3:0] buf_depth(input logic [1:0] p, input logic is_wr);
    if (!is_wr && p == PORT_L2) return L2_RD_BUFS;
    if (is_wr && p == PORT_EXT) return EXT_WR_BUFS;
    return DEF_BUFS;
  endfunction

  function automatic logic [4:0] buf_words(input logic [1:0] p, input logic is_wr);
    if (!is_wr && p == PORT_L2) return L2_RD_WORDS;
    if (is_wr && p == PORT_EXT) return EXT_WR_WORDS;
    return DEF_WORDS;
  endfunction
endpackage

// file: logic/tqa_fifo.sv
// First-in first-out priority queue held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module tqa_fifo #(
  parameter int DEPTH = 6
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Fill side
  input  wire logic                        push,
  input  wire logic [tqa_pkg::ENTRY_W-1:0] push_data,
  // Drain side
  input  wire logic                        pop,
  output logic      [tqa_pkg::ENTRY_W-1:0] head,
  output logic                             empty
);
  typedef struct packed {
    logic [tqa_pkg::QD_MAX-1:0][tqa_pkg::ENTRY_W-1:0] mem;
    logic [tqa_pkg::QIDX_W-1:0]                       wr;
    logic [tqa_pkg::QIDX_W-1:0]                       rd;
    logic [tqa_pkg::QIDX_W-1:0]                       count;
  } tqa_fifo_type;

  localparam logic [tqa_pkg::QIDX_W-1:0] LAST = tqa_pkg::QIDX_W'(DEPTH - 1);
  localparam logic [tqa_pkg::QIDX_W-1:0] ONE  = 4'h1;

  tqa_fifo_type st;
  tqa_fifo_type next_st;

  // Head is read in order, one entry per pop
  assign head  = st.mem[st.rd];
  assign empty = (st.count == '0);

  // Pointer and count update; credits keep push from ever meeting a full store
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = push_data;
      next_st.wr = (st.wr == LAST) ? '0 : st.wr + ONE;
    end
    if (pop && !empty) begin
      next_st.rd = (st.rd == LAST) ? '0 : st.rd + ONE;
    end
    if (push && !(pop && !empty)) next_st.count = st.count + ONE;
    if (!push && pop && !empty) next_st.count = st.count - ONE;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Never more entries than room
  fifo_room_a: assert property (@(posedge clock) disable iff (!rst_n) st.count <= DEPTH)
    else $error("queue holds more entries than its depth");
endmodule
`default_nettype wire

// file: tb/tqa_requestor_model.sv
// Requestor model: one pending request per requestor, held until acknowledged
`timescale 1ns/1ps
`default_nettype none
module tqa_requestor_model (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // Bench loads
  input  wire logic [2:0]      load,
  input  wire logic [2:0][1:0] load_prio,
  input  wire logic [2:0][7:0] load_data,
  output logic      [2:0]      busy,
  // Arbiter requestor side
  output logic      [2:0]      req_valid,
  output logic      [2:0][1:0] req_prio,
  output logic      [2:0][7:0] req_data,
  input  wire logic [2:0]      req_ack
);
  // Busy while a request still waits for its acknowledge
  assign busy = req_valid;
  // Falling edge drive; a stall never retires or replaces the pending word
  always_ff @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_valid <= 3'h0;
      req_prio  <= '1;
      req_data  <= '0;
    end else begin
      for (int r = 0; r < 3; r++) begin
        if (req_ack[r]) begin
          req_valid[r] <= 1'b0;
          req_data[r]  <= ~req_data[r]; // Released word shows no stale value
        end else if (load[r] && !req_valid[r]) begin
          req_valid[r] <= 1'b1;
          req_prio[r]  <= load_prio[r];
          req_data[r]  <= load_data[r];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/transfer_request_queue_arbiter_test.sv
// Self-checking bench for the transfer request queue arbiter
`timescale 1ns/1ps
`default_nettype none
module transfer_request_queue_arbiter_test;
  // Bench state
  logic clock, rst_n, hold;
  int   fail_count, checks_done, cycles;
  int   pend_rd [4];
  int   pend_wr [4];
  logic [1:0] rd_prios [$];
  logic [1:0] rd_ports [$];
  logic [4:0] rd_words [$];
  logic [4:0] wr_words [$];
  logic [1:0] wr_ports [$];
  logic [1:0] wr_prios [$];
  int         retired;
  // Model and design wiring
  logic [2:0]      load, busy, req_valid, req_ack, req_stall, set_active, xfer_done;
  logic [2:0][1:0] load_prio, req_prio;
  logic [2:0][7:0] load_data, req_data;
  logic            rd_cmd_valid, wr_cmd_valid;
  logic [1:0]      rd_cmd_port, rd_cmd_prio, wr_cmd_port, wr_cmd_prio;
  logic [4:0]      rd_cmd_words, wr_cmd_words;
  logic [3:0]      port_rd_done, port_wr_done;

  tqa_requestor_model partner (.clock, .rst_n, .load, .load_prio, .load_data, .busy,
    .req_valid, .req_prio, .req_data, .req_ack);
  tqa_arbiter uut (.clock, .rst_n, .req_valid, .req_prio, .req_data, .req_ack, .req_stall,
    .rd_cmd_valid, .rd_cmd_port, .rd_cmd_prio, .rd_cmd_words, .wr_cmd_valid, .wr_cmd_port,
    .wr_cmd_prio, .wr_cmd_words, .port_rd_done, .port_wr_done, .set_active, .xfer_done);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Port model: logs commands, frees one read and one write buffer per port each cycle unless held
  always @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_rd = '{default: 0};
      pend_wr = '{default: 0};
      port_rd_done <= 4'h0;
      port_wr_done <= 4'h0;
    end else begin
      if (rd_cmd_valid) begin
        pend_rd[rd_cmd_port]++;
        rd_ports.push_back(rd_cmd_port);
        rd_prios.push_back(rd_cmd_prio);
        rd_words.push_back(rd_cmd_words);
      end
      if (wr_cmd_valid) begin
        pend_wr[wr_cmd_port]++;
        wr_words.push_back(wr_cmd_words);
        wr_ports.push_back(wr_cmd_port);
        wr_prios.push_back(wr_cmd_prio);
      end
      // Retire pulses stand one cycle, so each is seen once here
      retired += $countones(xfer_done);
      for (int p = 0; p < 4; p++) begin
        port_rd_done[p] <= !hold && pend_rd[p] > 0;
        port_wr_done[p] <= !hold && pend_wr[p] > 0;
        if (!hold && pend_rd[p] > 0) pend_rd[p]--;
        if (!hold && pend_wr[p] > 0) pend_wr[p]--;
      end
    end
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Present one request once the requestor's slot is free
  task automatic put(input int r, input logic [1:0] p, input logic [7:0] d);
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (busy[r] !== 1'b0 && n < 3000);
    load_prio[r] <= p;
    load_data[r] <= d;
    load[r] <= 1'b1;
    @(negedge clock);
    load[r] <= 1'b0;
  endtask

  task automatic wait_idle(input int r);
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (busy[r] !== 1'b0 && n < 3000);
    check(8'(n == 3000), 8'h0);
  endtask

  task automatic wait_rd(input int cnt);
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (rd_ports.size() < cnt && n < 3000);
    check(8'(n == 3000), 8'h0);
  endtask

  // Release the ports and let every transfer retire
  task automatic drain();
    int n;
    hold <= 1'b0;
    n = 0;
    do begin @(negedge clock); n++; end while ((set_active !== 3'h0 || busy !== 3'h0) && n < 3000);
    check(8'(n == 3000), 8'h0);
    repeat (12) @(negedge clock);
    rd_ports.delete();
    rd_prios.delete();
    rd_words.delete();
    wr_words.delete();
    wr_ports.delete();
    wr_prios.delete();
  endtask

  task automatic rr_test();
    int most;
    most = 0;
    hold <= 1'b1;
    @(negedge clock);
    load_prio <= {2'h1, 2'h2, 2'h0};
    load_data <= {8'h9f, 8'h9f, 8'h9f};
    load <= 3'h7;
    @(negedge clock);
    load <= 3'h0;
    repeat (8) begin
      @(negedge clock);
      if ($countones(req_ack) > most) most = $countones(req_ack);
    end
    check(8'(most), 8'h1);
    check(8'(busy), 8'h0);
    check(8'(set_active), 8'h07);
    drain();
    $display("round robin test done");
  endtask

  task automatic prio_test();
    hold <= 1'b1;
    put(1, 2'h2, 8'h64);
    wait_rd(2);
    put(0, 2'h0, 8'h61);
    put(2, 2'h1, 8'h61);
    wait_idle(2);
    repeat (4) @(negedge clock);
    check(8'(rd_ports.size()), 8'h02);
    hold <= 1'b0;
    wait_rd(5);
    check(8'(rd_prios[2]), 8'h0);
    check(8'(rd_prios[3]), 8'h1);
    check(8'(rd_prios[4]), 8'h2);
    drain();
    $display("priority test done");
  endtask

  task automatic order_test();
    retired = 0;
    put(1, 2'h2, 8'he1);
    put(1, 2'h2, 8'ha1);
    put(1, 2'h2, 8'h61);
    wait_rd(3);
    check(8'(rd_ports[0]), 8'h3);
    check(8'(rd_ports[1]), 8'h2);
    check(8'(rd_ports[2]), 8'h1);
    drain();
    check(8'(retired), 8'h03);
    $display("order test done");
  endtask

  task automatic buf_test();
    hold <= 1'b1;
    put(1, 2'h2, 8'h1f);
    wait_rd(8);
    repeat (30) @(negedge clock);
    check(8'(rd_ports.size()), 8'h08);
    check(8'(wr_words.size()), 8'h02);
    check(8'(rd_words[0]), 8'h02);
    check(8'(wr_words[0]), 8'h10);
    check(8'(wr_ports[0]), 8'h1);
    check(8'(wr_prios[0]), 8'h2);
    drain();
    $display("buffer test done");
  endtask

  // Blocker occupies the set, lim requests fill the credits, one more stalls
  task automatic stall_case(input int r, input logic [1:0] p, input int lim);
    hold <= 1'b1;
    put(r, p, 8'h9f);
    for (int i = 0; i < lim; i++) put(r, p, 8'h91);
    wait_idle(r);
    check(8'(req_stall[r]), 8'h0);
    put(r, p, 8'h91);
    repeat (8) @(negedge clock);
    check(8'(req_stall[r]), 8'h1);
    check(8'(busy[r]), 8'h1);
    if (r == 2) put(1, 2'h2, 8'h91);
    if (r == 2) wait_idle(1);
    hold <= 1'b0;
    wait_idle(r);
    repeat (2) @(negedge clock);
    check(8'(req_stall[r]), 8'h0);
    drain();
    $display("stall test requestor %0d level %0d done", r, p);
  endtask

  initial begin
    rst_n = 1'b0;
    hold = 1'b0;
    load = 3'h0;
    load_prio = '0;
    load_data = '0;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    rr_test();
    prio_test();
    order_test();
    buf_test();
    stall_case(2, 2'h1, 2);
    stall_case(0, 2'h0, 6);
    stall_case(0, 2'h1, 3);
    stall_case(0, 2'h2, 3);
    stall_case(1, 2'h1, 8);
    stall_case(1, 2'h2, 8);
    end_sim();
  end
endmodule
`default_nettype wire
